//--- dv/tmc_core_assertions.sv
// Port-level assertion checker for the decoder core
`default_nettype none
module tmc_core_assertions
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] prog_addr,
  input wire logic [3:0] pe_oe_n,
  input wire logic [3:0] ph_o,
  input wire logic hold_n_i,
  input wire tmc_wr_t dac_wr_o,
  input wire logic clk_halted_o
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Address decode; any other offset must be refused
  wire logic hit;
  assign hit = paddr inside {OFS_CTRL, OFS_STAT, OFS_SR1, OFS_PCSET};
  // Named steps reused below
  sequence acc_s; psel && penable; endsequence
  sequence hold_hi_s; hold_n_i [*4]; endsequence
  no_wait_a: assert property (acc_s |-> pready)
    else $error("access phase without ready");
  bad_addr_a: assert property (acc_s |-> pslverr == !hit)
    else $error("slave error disagrees with decode");
  bad_data_a: assert property (psel && penable && !hit |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  tick_gap_a: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*8])
    else $error("program counter moved twice in a short span");
  dac_pulse_a: assert property (dac_wr_o.we |-> dac_wr_o.sel == 4'h0 ##1 !dac_wr_o.we)
    else $error("converter strobe malformed");
  pe_mode_a: assert property (pe_oe_n == 4'h0 || pe_oe_n == 4'hF)
    else $error("port E direction split");
  drain_low_a: assert property (ph_o == 4'h0)
    else $error("open drain port drives high");
  no_halt_a: assert property (hold_hi_s |-> !$rose(clk_halted_o))
    else $error("halted while hold inactive");
endmodule // tmc_core_assertions

bind tmc_core tmc_core_assertions tmc_core_assertions_inst (.pclk, .presetn, .paddr, .psel,
  .penable, .prdata, .pready, .pslverr, .prog_addr, .pe_oe_n, .ph_o, .hold_n_i, .dac_wr_o,
  .clk_halted_o);
`default_nettype wire

//--- dv/tmc_core_tb_top.sv
// Self-checking bench for the decoder core running a small program
`default_nettype none
module tmc_core_tb_top
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, hold_n_i, timer_ff_i, unlock_flipflop_i;
  logic pready, pslverr, err, clk_halted_o;
  logic [11:0] paddr, prog_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pa_i, pg_i, pe_i, pf_i, status2_i, pe_o, pe_oe_n, pf_o, pf_oe_n, pb_o;
  logic [3:0] pc_o, pd_o, ph_o, ph_oe_n, pi_o, status1_o;
  tmc_wr_t lcd_wr_o, pll_wr_o, dac_wr_o, uc_wr_o;
  tmc_wr_t lcd_seen, pll_seen, dac_seen, uc_seen;
  logic [15:0] rom [0:63];
  logic [11:0] row_pc [11];
  logic [3:0] row_pb [11];
  int num_errors, compares;
  // Program memory answers in the same cycle
  wire logic [15:0] prog_data;
  assign prog_data = rom[prog_addr[5:0]];

  tmc_core tmc_core_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .prog_addr, .prog_data, .pa_i, .pg_i, .pe_i, .pe_o,
    .pe_oe_n, .pf_i, .pf_o, .pf_oe_n, .pb_o, .pc_o, .pd_o, .ph_o, .ph_oe_n, .pi_o,
    .hold_n_i, .timer_ff_i, .unlock_flipflop_i, .status2_i, .status1_o, .lcd_wr_o,
    .pll_wr_o, .dac_wr_o, .uc_wr_o, .clk_halted_o);

  always #4 pclk = ~pclk;

  // Strobes last one cycle, so the last one of each kind is kept for the end checks
  always @(posedge pclk) begin
    if (lcd_wr_o.we) lcd_seen <= lcd_wr_o;
    if (pll_wr_o.we) pll_seen <= pll_wr_o;
    if (dac_wr_o.we) dac_seen <= dac_wr_o;
    if (uc_wr_o.we) uc_seen <= uc_wr_o;
  end

  function automatic logic [15:0] w(logic [5:0] op, logic [1:0] r, logic [3:0] c, logic [3:0] l);
    return {op, r, c, l};
  endfunction

  task automatic chk4(input logic [3:0] g, input logic [3:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: nibble %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: word %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Program of about fifty instruction cycles plus one halt; generous margin on top
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    wrap_up;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pa_i, pg_i, pe_i, pf_i, timer_ff_i, unlock_flipflop_i} = '0;
    hold_n_i = 1'b1;
    status2_i = 4'h3;
    // Arithmetic chain, skips, logic, moves, call and return
    rom = '{0: w(OP_MVI, 0, 1, 9), 1: w(OP_MVI, 0, 2, 8), 2: w(6'h10, 0, 2, 1),
      3: w(OP_OUT, 0, 1, PORT_B), 4: w(6'h12, 0, 2, 1), 5: w(OP_OUT, 0, 1, PORT_B),
      6: w(6'h11, 0, 2, 1), 7: w(OP_MVI, 0, 1, 4'hF), 8: w(OP_OUT, 0, 1, PORT_B),
      9: w(6'h18, 0, 2, 1), 10: w(6'h1A, 0, 2, 1), 11: w(OP_OUT, 0, 1, PORT_B),
      12: w(6'h1D, 0, 2, 9), 13: w(OP_MVI, 0, 1, 5), 14: w(OP_OUT, 0, 2, PORT_B),
      15: w(OP_SEQ, 0, 1, 1), 16: w(OP_MVI, 0, 1, 7), 17: w(OP_AND, 0, 2, 6),
      18: w(OP_OR, 0, 2, 1), 19: w(OP_OUT, 0, 2, PORT_B), 20: w(OP_EXL, 0, 2, 1),
      21: w(OP_OUT, 0, 1, PORT_B), 22: w(OP_SGE, 0, 2, 1), 23: w(OP_MVI, 1, 1, 4),
      24: w(OP_INDIRECT_STORE_MOVE, 1, 1, 2), 25: w(OP_ROW_LOCAL_MOVE, 1, 5, 7), 26: w(OP_OUT, 1, 5, PORT_B),
      27: w(OP_TMT, 1, 5, 4), 28: w(OP_MVI, 1, 5, 0), 29: 16'hC030, 30: {OP8_CLOCK_HALT_INSTR, 8'h00},
      31: {OP8_SS, 8'h05}, 32: {OP8_TST, 8'h03}, 33: w(OP_MVI, 0, 1, 0),
      34: w(OP_OUT, 0, 1, PORT_B), 35: {OP8_DAC, 8'h03}, 36: {OP8_CLOCK_HALT_INSTR, 8'h00},
      37: w(OP_LCP, 0, 2, 3), 38: w(OP_PLL, 0, 2, 1), 39: {OP8_UCS, 8'h09},
      40: {OP8_TTM, 8'h00}, 41: w(OP_MVI, 0, 2, 0), 42: w(OP_OUT, 0, 2, PORT_E),
      43: {OP8_SPB, PORT_B, 4'h8}, 44: w(OP_BANK, 2, 0, 0), 45: 16'hB02D,
      48: w(OP_OUT, 1, 5, PORT_B), 49: w(OP_OUT, 0, 2, PORT_B), 50: {OP8_RT, 8'h00},
      default: 16'h0000};
    row_pc = '{4, 6, 9, 12, 15, 20, 22, 27, 49, 50, 35};
    row_pb = '{1, 10, 2, 1, 15, 7, 6, 4, 4, 7, 6};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk4(pe_oe_n, 4'hF);
    chk4(pf_oe_n, 4'hF);
    chk4(pb_o, 4'h0);
    chk32({20'h0, prog_addr}, 32'h0);
    // Unmapped offset is refused and reads zero
    apb(1'b0, 12'h010, 32'h0);
    chk32(rd, 32'h0);
    chk4({3'h0, err}, 4'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    // Each row: program counter reached, value seen on port B
    for (int i = 0; i < 11; i++) begin
      while (prog_addr !== row_pc[i]) begin
        @(posedge pclk);
        #1;
      end
      chk4(pb_o, row_pb[i]);
    end
    chk4(status1_o, 4'h5);
    chk4({3'h0, clk_halted_o}, 4'h0);
    while (prog_addr !== 12'h024) begin
      @(posedge pclk);
      #1;
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk32(rd & 32'h0075_3FFF, 32'h0001_0024);
    apb(1'b0, OFS_SR1, 32'h0);
    chk32(rd & 32'h0000_000F, 32'h0000_0005);
    // Hold low lets the clock-stop at 0x24 halt the core; it resumes once hold returns
    hold_n_i <= 1'b0;
    while (clk_halted_o !== 1'b1) begin
      @(posedge pclk);
      #1;
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk32(rd & 32'h0075_3FFF, 32'h0005_0025);
    hold_n_i <= 1'b1;
    while (prog_addr !== 12'h02D) begin
      @(posedge pclk);
      #1;
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk32(rd & 32'h0075_3FFF, 32'h0001_202D);
    chk32({19'h0, lcd_seen}, {19'h0, 1'b1, 4'h3, SEG_ROM[7]});
    chk32({19'h0, pll_seen}, {19'h0, 1'b1, 4'h6, 8'h07});
    chk32({19'h0, dac_seen}, {19'h0, 1'b1, 4'h0, 8'h03});
    chk32({19'h0, uc_seen}, {19'h0, 1'b1, UC_SEL_W1, 8'h09});
    // The skipped immediate move would have cleared the digit sent to port E
    chk4(pe_o, 4'h7);
    chk4(pe_oe_n, 4'h0);
    chk4(pb_o, 4'hE);
    wrap_up;
  end
endmodule // tmc_core_tb_top
`default_nettype wire

//--- rtl/tmc_core.sv
// Instruction decoder and executor for the 4-bit tuner microcontroller core
// Behaviour
// - Words carry 2-bit row, 4-bit column and 4-bit register/immediate/mask fields
// - Register operand is digit 00..0FH of bank 0 chosen by register field
// - Add memory to register or immediate to memory, carry optional, skip on carry
// - Subtract memory or immediate, borrow optional, skip variants skip on borrow
// - Compare without storing; skip on equal or on no borrow
// - Memory AND/OR immediate into memory; register XOR memory into register
// - Indirect moves address row field plus column held in a register
// - Row-local move copies one digit to another within the same row
// - Jumps and calls load 12-bit address; call pushes PC+1; returns pop
// - Timer or unlock flip-flop test skips when flip-flop is clear
// - Mask sets/clears status register 1; tests status register 2 all one/zero
// - Bank-select loads the active data bank from a 2-bit field
// - Memory bit test skips when masked bits are all one or all zero
// - Port in, out, bit set/clear and masked tests by 4-bit port number
// - Display write sends digit directly or through the segment decoding array
// - Clock-halt instruction stops the clock only while hold is low
// - Memory digits addressed with a general register go to synthesizer registers
// - Converter-load instruction loads the D/A registers with its data
// - Port direction instruction sets each second bidirectional port pin separately
// - First bidirectional port latches input after in/tests, output after out/set/clear
//
// Implementation choices: the placing of the registers and register access over APB.
`default_nettype none
module tmc_core
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [11:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic [3:0] pa_i,
  input wire logic [3:0] pg_i,
  input wire logic [3:0] pe_i,
  output logic [3:0] pe_o,
  output logic [3:0] pe_oe_n,
  input wire logic [3:0] pf_i,
  output logic [3:0] pf_o,
  output logic [3:0] pf_oe_n,
  output logic [3:0] pb_o,
  output logic [3:0] pc_o,
  output logic [3:0] pd_o,
  output logic [3:0] ph_o,
  output logic [3:0] ph_oe_n,
  output logic [3:0] pi_o,
  input wire logic hold_n_i,
  input wire logic timer_ff_i,
  input wire logic unlock_flipflop_i,
  input wire logic [3:0] status2_i,
  output logic [3:0] status1_o,
  output tmc_wr_t lcd_wr_o,
  output tmc_wr_t pll_wr_o,
  output tmc_wr_t dac_wr_o,
  output tmc_wr_t uc_wr_o,
  output logic clk_halted_o
);

  // Architectural state
  logic [3:0] ram_q [256];
  logic [3:0] port_q [16];
  logic [11:0] stack_q [8];
  logic [11:0] pc_q;
  logic [2:0] sp_q;
  logic [1:0] bank_q;
  logic carry_q;
  logic skip_q;
  logic run_q;
  logic [3:0] sr1_q;
  logic [3:0] fdir_q;
  logic pe_out_q;
  logic [8:0] cnt_q;
  logic [31:0] prdata_q;
  tmc_state_t state_q;
  tmc_state_t state_d;
  tmc_wr_t lcd_q, pll_q, dac_q, uc_q;
  logic [15:0] sync1_q, sync2_q;
  logic hold1_q, hold2_q;

  // Port and hold pins pass two flops; timer, unlock and status 2 inputs feed the logic directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      hold1_q <= 1'b1;
      hold2_q <= 1'b1;
    end else begin
      sync1_q <= {pf_i, pe_i, pg_i, pa_i};
      sync2_q <= sync1_q;
      hold1_q <= hold_n_i;
      hold2_q <= hold1_q;
    end
  end

  wire [3:0] pa_s = sync2_q[3:0];
  wire [3:0] pg_s = sync2_q[7:4];
  wire [3:0] pe_s = sync2_q[11:8];
  wire [3:0] pf_s = sync2_q[15:12];

  // Instruction cycle divider: one step enable per instruction cycle
  wire tick = (cnt_q == 9'(CYC_CNT - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 9'h000;
    else cnt_q <= tick ? 9'h000 : cnt_q + 9'h001;
  end

  // Field extraction
  tmc_instr_t ir;
  assign ir = tmc_instr_t'(prog_data);
  wire [5:0] op6 = ir.op;
  wire [1:0] row = ir.row_field;
  wire [3:0] col = ir.column_field;
  wire [3:0] lo = ir.gp_register_field;

  // Data memory operands
  wire [7:0] m_addr = {bank_q, row, col};
  wire [7:0] r_addr = {BANK_RST, 2'b00, lo};
  wire [3:0] m_val = ram_q[m_addr];
  wire [3:0] r_val = ram_q[r_addr];
  wire [7:0] ind_addr = {bank_q, row, r_val};
  wire [3:0] ind_val = ram_q[ind_addr];
  wire [7:0] src_addr = {bank_q, row, lo};
  wire [3:0] src_val = ram_q[src_addr];

  // Arithmetic family 01_sub_imm_carry_skip
  wire is_arith = (op6[5:4] == 2'b01);
  wire ar_sub = op6[3];
  wire ar_imm = op6[2];
  wire [3:0] ar_a = ar_imm ? m_val : r_val;
  wire [3:0] ar_b = ar_imm ? lo : m_val;
  wire ar_cin = op6[1] & carry_q;
  wire [4:0] ar_sum = {1'b0, ar_a} + {1'b0, ar_b} + {4'h0, ar_cin};
  wire [4:0] ar_dif = {1'b0, ar_a} - {1'b0, ar_b} - {4'h0, ar_cin};
  wire [4:0] ar_res = ar_sub ? ar_dif : ar_sum;

  // Compare forms: bit 3 picks immediate, bit 1 picks greater-or-equal
  wire [3:0] cp_a = op6[3] ? m_val : r_val;
  wire [3:0] cp_b = op6[3] ? lo : m_val;
  wire [4:0] cp_dif = {1'b0, cp_a} - {1'b0, cp_b};
  wire cp_skip = op6[1] ? ~cp_dif[4] : (cp_dif[3:0] == 4'h0);

  // Port selection and read-back; bit group carries the port in the column slot
  wire bit_grp = (ir[15:12] == 4'hF);
  wire [3:0] pidx = bit_grp ? col : lo;
  wire [3:0] pf_rd = (port_q[PORT_F] & fdir_q) | (pf_s & ~fdir_q);
  wire [3:0] pe_rd = pe_out_q ? port_q[PORT_E] : pe_s;
  wire [3:0] port_val = (pidx == PORT_A) ? pa_s :
                        (pidx == PORT_E) ? pe_rd :
                        (pidx == PORT_F) ? pf_rd :
                        (pidx == PORT_G) ? pg_s : port_q[pidx];
  wire [3:0] pbits = port_val & lo;

  // Execution decode
  logic ram_we;
  logic [7:0] ram_wa;
  logic [3:0] ram_wd;
  logic skip_c, carry_we, push, pop, bank_we, halt_req;
  logic port_we, pe_in_set, pe_out_set, fdir_we, sr1_we;
  logic [3:0] port_wd, sr1_d;
  logic [11:0] pc_d;
  tmc_wr_t lcd_d, pll_d, dac_d, uc_d;
  wire [11:0] pc_inc = pc_q + 12'h001;
  wire pe_hit = (pidx == PORT_E);

  always_comb begin
    ram_we = 1'b0;
    ram_wa = m_addr;
    ram_wd = m_val;
    skip_c = 1'b0;
    carry_we = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    bank_we = 1'b0;
    halt_req = 1'b0;
    port_we = 1'b0;
    port_wd = port_q[pidx];
    pe_in_set = 1'b0;
    pe_out_set = 1'b0;
    fdir_we = 1'b0;
    sr1_we = 1'b0;
    sr1_d = sr1_q;
    pc_d = pc_inc;
    lcd_d = '0;
    pll_d = '0;
    dac_d = '0;
    uc_d = '0;
    if (is_arith) begin
      ram_we = 1'b1;
      ram_wa = ar_imm ? m_addr : r_addr;
      ram_wd = ar_res[3:0];
      carry_we = 1'b1;
      skip_c = op6[0] & ar_res[4];
    end else if (ir[15:12] == OP4_JMP) begin
      pc_d = ir[11:0];
    end else if (ir[15:12] == OP4_CAL) begin
      pc_d = ir[11:0];
      push = 1'b1;
    end else begin
      case (op6)
        OP_SEQ, OP_SGE, OP_SEQI, OP_SGEI: skip_c = cp_skip;
        OP_AND: begin
          ram_we = 1'b1;
          ram_wd = m_val & lo;
        end
        OP_OR: begin
          ram_we = 1'b1;
          ram_wd = m_val | lo;
        end
        OP_EXL: begin
          ram_we = 1'b1;
          ram_wa = r_addr;
          ram_wd = r_val ^ m_val;
        end
        OP_LD: begin
          ram_we = 1'b1;
          ram_wa = r_addr;
        end
        OP_ST: begin
          ram_we = 1'b1;
          ram_wd = r_val;
        end
        OP_INDIRECT_STORE_MOVE: begin
          ram_we = 1'b1;
          ram_wa = ind_addr;
        end
        OP_INDIRECT_LOAD_MOVE: begin
          ram_we = 1'b1;
          ram_wd = ind_val;
        end
        OP_ROW_LOCAL_MOVE: begin
          ram_we = 1'b1;
          ram_wd = src_val;
        end
        OP_MVI: begin
          ram_we = 1'b1;
          ram_wd = lo;
        end
        OP_PLL: pll_d = '{we: 1'b1, sel: r_val, data: {4'h0, m_val}};
        OP_TMT: skip_c = ((m_val & lo) == lo);
        OP_TMF: skip_c = ((m_val & lo) == 4'h0);
        OP_BANK: bank_we = 1'b1;
        OP_LCD: lcd_d = '{we: 1'b1, sel: lo, data: {4'h0, m_val}};
        OP_LCP: lcd_d = '{we: 1'b1, sel: lo, data: SEG_ROM[m_val]};
        OP_IN: begin
          ram_we = 1'b1;
          ram_wd = port_val;
          pe_in_set = pe_hit;
        end
        OP_OUT: begin
          port_we = 1'b1;
          port_wd = m_val;
          pe_out_set = pe_hit;
        end
        default: begin
          case (ir[15:8])
            OP8_UCS: uc_d = '{we: 1'b1, sel: UC_SEL_W1, data: {4'h0, lo}};
            OP8_UCC: uc_d = '{we: 1'b1, sel: UC_SEL_W2, data: {4'h0, lo}};
            OP8_DAC: dac_d = '{we: 1'b1, sel: 4'h0, data: {4'h0, lo}};
            OP8_FPC: fdir_we = 1'b1;
            OP8_CLOCK_HALT_INSTR: halt_req = ~hold2_q;
            OP8_RT, OP8_RTI: begin
              pop = 1'b1;
              pc_d = stack_q[sp_q - 3'h1];
            end
            OP8_TTM: skip_c = ~timer_ff_i;
            OP8_TUL: skip_c = ~unlock_flipflop_i;
            OP8_SS: begin
              sr1_we = 1'b1;
              sr1_d = sr1_q | lo;
            end
            OP8_RS: begin
              sr1_we = 1'b1;
              sr1_d = sr1_q & ~lo;
            end
            OP8_TST: skip_c = ((status2_i & lo) == lo);
            OP8_TSF: skip_c = ((status2_i & lo) == 4'h0);
            OP8_SPB: begin
              port_we = 1'b1;
              port_wd = port_q[pidx] | lo;
              pe_out_set = pe_hit;
            end
            OP8_RPB: begin
              port_we = 1'b1;
              port_wd = port_q[pidx] & ~lo;
              pe_out_set = pe_hit;
            end
            OP8_TPT: begin
              skip_c = (pbits == lo);
              pe_in_set = pe_hit;
            end
            OP8_TPF: begin
              skip_c = (pbits == 4'h0);
              pe_in_set = pe_hit;
            end
            default: ;
          endcase
        end
      endcase
    end
  end

  // Run/halt sequencing; a halted core resumes once hold returns high
  wire step = tick && (state_q == ST_RUN);
  wire exec = step && !skip_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STOP: if (run_q) state_d = ST_RUN;
      ST_RUN: begin
        if (!run_q) state_d = ST_STOP;
        else if (exec && halt_req) state_d = ST_HALT;
      end
      ST_HALT: begin
        if (!run_q) state_d = ST_STOP;
        else if (hold2_q) state_d = ST_RUN;
      end
      default: state_d = ST_STOP;
    endcase
  end

  // APB decode; zero wait states so pready is always high
  wire apb_wr = psel && penable && pwrite;
  wire addr_hit = (paddr == OFS_CTRL) || (paddr == OFS_STAT) ||
                  (paddr == OFS_SR1) || (paddr == OFS_PCSET);
  wire [31:0] stat_word = (32'(pc_q)) | (32'(bank_q) << STAT_BANK_POS) |
                          (32'(carry_q) << STAT_CARRY_POS) |
                          (32'(skip_q) << STAT_SKIP_POS) |
                          (32'(state_q == ST_HALT) << STAT_HALT_POS) |
                          (32'(sp_q) << STAT_SP_POS);
  wire [31:0] rd_mux = (paddr == OFS_CTRL) ? {31'h0, run_q} :
                       (paddr == OFS_STAT) ? stat_word :
                       (paddr == OFS_SR1) ? {28'h0, sr1_q} :
                       (paddr == OFS_PCSET) ? {20'h0, pc_q} : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_q;

  // Read data is captured in the setup cycle so it stands from a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h0000_0000;
    else if (psel && !penable) prdata_q <= rd_mux;
  end

  // Control and sequencing state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_STOP;
      run_q <= 1'b0;
      pc_q <= PC_RST;
      skip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (apb_wr && paddr == OFS_CTRL) run_q <= pwdata[0];
      // PC load is only honoured while stopped to avoid racing the fetch
      if (apb_wr && paddr == OFS_PCSET && state_q == ST_STOP) pc_q <= pwdata[11:0];
      else if (step) pc_q <= exec ? pc_d : pc_inc;
      if (step) skip_q <= exec && skip_c;
    end
  end

  // Flags, bank, status register 1, stack pointer and port direction state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
      bank_q <= BANK_RST;
      sr1_q <= NIB_RST;
      sp_q <= 3'h0;
      fdir_q <= NIB_RST;
      pe_out_q <= 1'b0;
    end else if (exec) begin
      if (carry_we) carry_q <= ar_res[4];
      if (bank_we) bank_q <= row;
      if (sr1_we) sr1_q <= sr1_d;
      if (push) sp_q <= sp_q + 3'h1;
      else if (pop) sp_q <= sp_q - 3'h1;
      if (fdir_we) fdir_q <= lo;
      if (pe_out_set) pe_out_q <= 1'b1;
      else if (pe_in_set) pe_out_q <= 1'b0;
    end
  end

  // Peripheral strobes are one pclk wide, taken from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcd_q <= '0;
      pll_q <= '0;
      dac_q <= '0;
      uc_q <= '0;
    end else begin
      lcd_q <= exec ? lcd_d : '0;
      pll_q <= exec ? pll_d : '0;
      dac_q <= exec ? dac_d : '0;
      uc_q <= exec ? uc_d : '0;
    end
  end

  // Output port latches, one per port number
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) port_q[gi] <= NIB_RST;
        else if (exec && port_we && pidx == 4'(gi)) port_q[gi] <= port_wd;
      end
    end
  endgenerate

  // Data memory and stack hold no reset; software initialises them
  always_ff @(posedge pclk) begin
    if (exec && ram_we) ram_q[ram_wa] <= ram_wd;
    if (exec && push) stack_q[sp_q] <= pc_inc;
  end

  // Pin drive; output enables are low while driving
  assign pe_o = port_q[PORT_E];
  assign pe_oe_n = {4{~pe_out_q}};
  assign pf_o = port_q[PORT_F];
  assign pf_oe_n = ~fdir_q;
  assign pb_o = port_q[PORT_B];
  assign pc_o = port_q[PORT_C];
  assign pd_o = port_q[PORT_D];
  assign ph_o = 4'h0;
  assign ph_oe_n = ~port_q[PORT_H];
  assign pi_o = port_q[PORT_I];
  assign prog_addr = pc_q;
  assign status1_o = sr1_q;
  assign lcd_wr_o = lcd_q;
  assign pll_wr_o = pll_q;
  assign dac_wr_o = dac_q;
  assign uc_wr_o = uc_q;
  assign clk_halted_o = (state_q == ST_HALT);

endmodule // tmc_core
`default_nettype wire

//--- rtl/tmc_pkg.sv
// Package for the tuner microcontroller instruction decoder: codes, offsets, carriers
`default_nettype none
package tmc_pkg;

  // Instruction cycle timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CYCLE_TIME_PS = 2670000;
  localparam int CYC_CNT = CYCLE_TIME_PS / CLK_PERIOD_PS;

  // APB register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_SR1 = 12'h008;
  localparam logic [11:0] OFS_PCSET = 12'h00C;

  // Status word field positions
  localparam int STAT_BANK_POS = 12;
  localparam int STAT_CARRY_POS = 16;
  localparam int STAT_SKIP_POS = 17;
  localparam int STAT_HALT_POS = 18;
  localparam int STAT_SP_POS = 20;

  // Reset values
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [3:0] NIB_RST = 4'h0;

  // Port numbers
  localparam logic [3:0] PORT_A = 4'h0;
  localparam logic [3:0] PORT_B = 4'h1;
  localparam logic [3:0] PORT_C = 4'h2;
  localparam logic [3:0] PORT_D = 4'h3;
  localparam logic [3:0] PORT_E = 4'h4;
  localparam logic [3:0] PORT_F = 4'h5;
  localparam logic [3:0] PORT_G = 4'h6;
  localparam logic [3:0] PORT_H = 4'h7;
  localparam logic [3:0] PORT_I = 4'h8;

  // Six-bit opcodes (arithmetic family 01xxxx decoded by its bits)
  localparam logic [5:0] OP_SEQ = 6'h01;
  localparam logic [5:0] OP_SGE = 6'h03;
  localparam logic [5:0] OP_EXL = 6'h08;
  localparam logic [5:0] OP_AND = 6'h0C;
  localparam logic [5:0] OP_SEQI = 6'h0D;
  localparam logic [5:0] OP_OR = 6'h0E;
  localparam logic [5:0] OP_SGEI = 6'h0F;
  localparam logic [5:0] OP_LD = 6'h20;
  localparam logic [5:0] OP_ST = 6'h21;
  localparam logic [5:0] OP_INDIRECT_STORE_MOVE = 6'h22;
  localparam logic [5:0] OP_INDIRECT_LOAD_MOVE = 6'h23;
  localparam logic [5:0] OP_ROW_LOCAL_MOVE = 6'h24;
  localparam logic [5:0] OP_MVI = 6'h25;
  localparam logic [5:0] OP_PLL = 6'h26;
  localparam logic [5:0] OP_TMT = 6'h29;
  localparam logic [5:0] OP_TMF = 6'h2B;
  localparam logic [5:0] OP_BANK = 6'h34;
  localparam logic [5:0] OP_LCD = 6'h38;
  localparam logic [5:0] OP_LCP = 6'h39;
  localparam logic [5:0] OP_IN = 6'h3A;
  localparam logic [5:0] OP_OUT = 6'h3B;
  localparam logic [3:0] OP4_JMP = 4'hB;
  localparam logic [3:0] OP4_CAL = 4'hC;

  // Eight-bit opcodes
  localparam logic [7:0] OP8_NOP = 8'h00;
  localparam logic [7:0] OP8_UCS = 8'h01;
  localparam logic [7:0] OP8_DAC = 8'h02;
  localparam logic [7:0] OP8_UCC = 8'h03;
  localparam logic [7:0] OP8_FPC = 8'h10;
  localparam logic [7:0] OP8_CLOCK_HALT_INSTR = 8'h11;
  localparam logic [7:0] OP8_RT = 8'hD4;
  localparam logic [7:0] OP8_RTI = 8'hD5;
  localparam logic [7:0] OP8_TTM = 8'hD6;
  localparam logic [7:0] OP8_TUL = 8'hD7;
  localparam logic [7:0] OP8_SS = 8'hDC;
  localparam logic [7:0] OP8_RS = 8'hDD;
  localparam logic [7:0] OP8_TST = 8'hDE;
  localparam logic [7:0] OP8_TSF = 8'hDF;
  localparam logic [7:0] OP8_SPB = 8'hF0;
  localparam logic [7:0] OP8_RPB = 8'hF5;
  localparam logic [7:0] OP8_TPT = 8'hFA;
  localparam logic [7:0] OP8_TPF = 8'hFF;

  // Peripheral register selects for the counter control words
  localparam logic [3:0] UC_SEL_W1 = 4'h1;
  localparam logic [3:0] UC_SEL_W2 = 4'h2;

  // Seven-segment pattern per digit value, entry 0 in the low byte
  localparam logic [15:0][7:0] SEG_ROM = {
    8'h71, 8'h79, 8'h5E, 8'h39, 8'h7C, 8'h77, 8'h6F, 8'h7F,
    8'h07, 8'h7D, 8'h6D, 8'h66, 8'h4F, 8'h5B, 8'h06, 8'h3F};

  typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_HALT} tmc_state_t;

  // Instruction word fields
  typedef struct packed {
    logic [5:0] op;
    logic [1:0] row_field;
    logic [3:0] column_field;
    logic [3:0] gp_register_field;
  } tmc_instr_t;

  // One-cycle write strobe to a peripheral register
  typedef struct packed {
    logic we;
    logic [3:0] sel;
    logic [7:0] data;
  } tmc_wr_t;

endpackage
`default_nettype wire
